// >>> design/tkirq_pkg.sv
// Package with register map, field positions, reset values and timing for the touchkey interrupt controller.
`default_nettype none
package tkirq_pkg;
   localparam logic [7:0] ADDR_CTRL     = 8'h08;
   localparam logic [7:0] ADDR_EN       = 8'h09;
   localparam logic [7:0] ADDR_STA      = 8'h0a;
   localparam logic [7:0] RST_CTRL      = 8'h01;
   localparam logic [7:0] RST_EN        = 8'h01;
   localparam logic [7:0] RST_STA       = 8'h09;
   localparam int         BIT_GLOBAL_EN = 0;
   localparam int         BIT_TYPE      = 1;
   localparam int         BIT_POLARITY  = 2;
   localparam int         BIT_POR       = 0;
   localparam int         BIT_FIFO      = 1;
   localparam int         BIT_SYS       = 2;
   localparam int         BIT_GPIO      = 7;
   localparam logic [7:0] SRC_MASK      = 8'h87;
   localparam logic [7:0] CTRL_MASK     = 8'h07;
   localparam int         CLK_HZ        = 25000000;
   localparam int         PULSE_NS      = 200;
   localparam int         PULSE_CYC     = (PULSE_NS * (CLK_HZ / 1000000)) / 1000;

   typedef struct packed {
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } tkirq_reg_req_type;

   typedef struct packed {
      logic gpio;
      logic sys_conv;
      logic sys_eoc;
      logic fifo_nonempty;
      logic por;
   } tkirq_event_type;
endpackage : tkirq_pkg
`default_nettype wire

// >>> design/tkirq_pulse.sv
// Retriggerable pulse stretcher that holds its output for WIDTH cycles after the last trigger, for edge signalling.
`default_nettype none
module tkirq_pulse #(
   parameter int WIDTH = 5
) (
   input  wire logic clk_i,     // System clock.
   input  wire logic sys_rst_i, // Synchronous reset, active high.
   input  wire logic trig_i,    // One-cycle trigger.
   output logic      pulse_o    // Stretched pulse.
);
   typedef struct packed {
      logic [7:0] cnt;
   } tkirq_pulse_state_type;

   tkirq_pulse_state_type state, next_state;

   always_comb begin
      next_state = state;
      if (trig_i) begin
         next_state.cnt = 8'(WIDTH);
      end else if (state.cnt != 8'h00) begin
         next_state.cnt = state.cnt - 8'h01;
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign pulse_o = (state.cnt != 8'h00);
endmodule : tkirq_pulse
`default_nettype wire

// >>> design/tkirq_ctrl.sv
// Interrupt controller: source latching, enables, and output pin shaping.
// Function
// - Global enable gates the interrupt pin.
// - Per-source enable lets pending event drive pin.
// - Events latch into status even when masked.
// - Status bits clear on writing one.
// - FIFO status stays set while FIFO nonempty.
// - Bit seven is aggregated GPIO transition source.
// - Bit two merges conversion and end events.
`default_nettype none
module tkirq_ctrl
   import tkirq_pkg::*;
(
   input  wire logic                         clk_i,      // System clock, 25 MHz.
   input  wire logic                         sys_rst_i,  // Synchronous reset, active high.
   input  wire tkirq_pkg::tkirq_reg_req_type req_i,      // Register write request from the serial interface.
   input  wire logic                         req_valid_i, // Request strobe, one cycle.
   input  wire tkirq_pkg::tkirq_event_type   event_i,    // Event pulses; fifo_nonempty is a level.
   output logic [7:0]                        ctrl_o,     // Control register contents.
   output logic [7:0]                        enable_o,   // Source enable register contents.
   output logic [7:0]                        status_o,   // Status register contents.
   output logic                              irq_o,      // Interrupt pin output level.
   output logic                              irq_oe_o    // Interrupt pin output enable.
);
   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] enable;
      logic [7:0] status;
      logic       pend_q;
      logic       irq;
      logic       irq_oe;
   } tkirq_state_type;

   tkirq_state_type state, next_state;
   logic            pulse;
   logic            pending;
   logic            asserted;
   logic            wr_en;
   logic            wr_sta;
   logic [7:0]      set_bits;
   logic [7:0]      clr_bits;

   assign wr_en  = req_valid_i && req_i.wr;
   assign wr_sta = wr_en && (req_i.addr == ADDR_STA);

   // Pending uses the registered state so the pin follows status by one cycle in level mode and by two in edge mode.
   assign pending = state.ctrl[BIT_GLOBAL_EN] && ((state.status & state.enable & SRC_MASK) != 8'h00);

   tkirq_pulse #(
      .WIDTH (PULSE_CYC)
   ) u_pulse (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .trig_i    (pending && !state.pend_q),
      .pulse_o   (pulse)
   );

   always_comb begin
      set_bits = 8'h00;
      clr_bits = 8'h00;
      set_bits[BIT_GPIO] = event_i.gpio;
      set_bits[BIT_SYS]  = event_i.sys_conv | event_i.sys_eoc;
      set_bits[BIT_FIFO] = event_i.fifo_nonempty;
      set_bits[BIT_POR]  = event_i.por;
      if (wr_sta) begin
         clr_bits = req_i.wdata & SRC_MASK;
      end
      next_state = state;
      if (wr_en && req_i.addr == ADDR_CTRL) begin
         next_state.ctrl = req_i.wdata & CTRL_MASK;
      end
      if (wr_en && req_i.addr == ADDR_EN) begin
         next_state.enable = req_i.wdata & SRC_MASK;
      end
      // Set wins over clear, so an event arriving with the clear is kept.
      next_state.status = (state.status & ~clr_bits) | set_bits;
      next_state.pend_q = pending;
      // A pulse already under way is cut when the global enable drops, so the pin never fires while disabled.
      asserted = state.ctrl[BIT_TYPE] ? (pulse && state.ctrl[BIT_GLOBAL_EN]) : pending;
      if (state.ctrl[BIT_POLARITY]) begin
         next_state.irq    = asserted;
         next_state.irq_oe = 1'b1;
      end else begin
         next_state.irq    = 1'b0;
         next_state.irq_oe = asserted;
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         state <= '{ctrl: RST_CTRL, enable: RST_EN, status: RST_STA, pend_q: 1'b0, irq: 1'b0, irq_oe: 1'b0};
      end else begin
         state <= next_state;
      end
   end

   assign ctrl_o   = state.ctrl;
   assign enable_o = state.enable;
   assign status_o = state.status;
   assign irq_o    = state.irq;
   assign irq_oe_o = state.irq_oe;

   global_off_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !ctrl_o[BIT_GLOBAL_EN] |=> ($past(ctrl_o[BIT_POLARITY]) ? !irq_o : !irq_oe_o))
      else $error("Interrupt pin asserted while globally disabled.");
   ctrl_write_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      wr_en && (req_i.addr == ADDR_CTRL) |=> ctrl_o == ($past(req_i.wdata) & CTRL_MASK))
      else $error("Control register write not applied.");
   // Enable writes keep the reserved bits clear whatever the host sends.
   enable_write_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      wr_en && (req_i.addr == ADDR_EN) |=> enable_o == ($past(req_i.wdata) & SRC_MASK))
      else $error("Enable register write not applied.");
   fifo_clear_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      wr_sta && req_i.wdata[BIT_FIFO] && !event_i.fifo_nonempty |=> !status_o[BIT_FIFO])
      else $error("FIFO status not cleared once empty.");
   high_drive_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      $past(ctrl_o[BIT_POLARITY]) && !$past(sys_rst_i) |-> irq_oe_o)
      else $error("Active high output not driven.");
   level_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !ctrl_o[BIT_TYPE] && ctrl_o[BIT_POLARITY] && pending |=> irq_o)
      else $error("Level output not asserted while pending.");
   masked_src_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ((status_o & enable_o & SRC_MASK) == 8'h00) && !ctrl_o[BIT_TYPE] && !ctrl_o[BIT_POLARITY] |=> !irq_oe_o)
      else $error("Masked source drove the interrupt pin.");
   latch_masked_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      event_i.por |=> status_o[BIT_POR])
      else $error("Event not latched into status.");
   w1c_clear_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      wr_sta && req_i.wdata[BIT_POR] && !event_i.por |=> !status_o[BIT_POR])
      else $error("Write one did not clear status bit.");
   w0_keep_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      wr_sta && !req_i.wdata[BIT_GPIO] && status_o[BIT_GPIO] |=> status_o[BIT_GPIO])
      else $error("Write zero changed status bit.");
   fifo_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      event_i.fifo_nonempty |=> status_o[BIT_FIFO])
      else $error("FIFO status cleared while data remains.");
   gpio_bit_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      event_i.gpio |=> status_o[BIT_GPIO])
      else $error("GPIO event not on bit seven.");
   sys_merge_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      event_i.sys_conv || event_i.sys_eoc |=> status_o[BIT_SYS])
      else $error("System event not merged on bit two.");
   low_drain_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !$past(ctrl_o[BIT_POLARITY]) && !$past(sys_rst_i) |-> !irq_o)
      else $error("Active low output drove high.");
   pulse_len_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ctrl_o[BIT_TYPE] && ctrl_o[BIT_POLARITY] && $rose(pulse) |-> pulse [*5] ##1 !pulse)
      else $error("Edge pulse width wrong.");

   level_irq_c: cover property (@(posedge clk_i) disable iff (sys_rst_i) !ctrl_o[BIT_TYPE] && irq_oe_o);
   edge_irq_c: cover property (@(posedge clk_i) disable iff (sys_rst_i) ctrl_o[BIT_TYPE] && $rose(pulse));
   clear_c: cover property (@(posedge clk_i) disable iff (sys_rst_i) wr_sta && req_i.wdata != 8'h00);
   fifo_hold_c: cover property (@(posedge clk_i) disable iff (sys_rst_i) wr_sta && req_i.wdata[BIT_FIFO] && event_i.fifo_nonempty);
endmodule : tkirq_ctrl
`default_nettype wire

// >>> dv/tkirq_host_model.sv
// Host model: register writer plus a pulled-up interrupt pin reader.
`default_nettype none
module tkirq_host_model
   import tkirq_pkg::*;
(
   input  wire logic                    clk_i,      // System clock.
   input  wire logic                    irq_i,      // Pin level from the device.
   input  wire logic                    irq_oe_i,   // Pin enable from the device.
   input  wire logic                    pol_i,      // Polarity the host configured.
   output tkirq_pkg::tkirq_reg_req_type req_o,      // Write request.
   output logic                         valid_o,    // Request strobe.
   output logic                         asserted_o  // Pin reads as asserted.
);
   timeunit 1ns;
   timeprecision 1ns;
   logic pin;
   assign pin = irq_oe_i ? irq_i : 1'b1;
   assign asserted_o = pol_i ? pin : !pin;
   initial begin
      req_o = '0;
      valid_o = 1'b0;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      #1;
      req_o = '{wr: 1'b1, addr: a, wdata: (a == ADDR_EN) ? (d & SRC_MASK) : d};
      valid_o = 1'b1;
      @(posedge clk_i);
      #1;
      valid_o = 1'b0;
      // Stale data is scrambled so nothing can rely on it after release.
      req_o = ~req_o;
   endtask : wr
endmodule : tkirq_host_model
`default_nettype wire

// >>> dv/tkirq_ctrl_tb_top.sv
// Self-checking bench for the touchkey interrupt controller.
`default_nettype none
module tkirq_ctrl_tb_top
   import tkirq_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {int sel; logic [7:0] exp;} tkirq_note_type;
   logic              clk_i = 1'b0;
   logic              sys_rst_i = 1'b1;
   logic              valid;
   logic              asrt;
   logic [7:0]        ctrl, en, sta;
   logic              irq, oe;
   logic [16:0]       rnd = 17'h18501;
   tkirq_reg_req_type req;
   tkirq_event_type   ev = '0;
   tkirq_note_type    q[$];
   tkirq_note_type    n;
   int                err_count = 0;
   int                compares = 0;
   int                plen;
   event              go;
   string             nm[5] = '{"ctrl", "enable", "status", "pin", "pulse_len"};
   tkirq_ctrl i_dut(.clk_i(clk_i), .sys_rst_i(sys_rst_i), .req_i(req), .req_valid_i(valid), .event_i(ev),
      .ctrl_o(ctrl), .enable_o(en), .status_o(sta), .irq_o(irq), .irq_oe_o(oe));
   tkirq_host_model i_host(.clk_i(clk_i), .irq_i(irq), .irq_oe_i(oe), .pol_i(ctrl[BIT_POLARITY]),
      .req_o(req), .valid_o(valid), .asserted_o(asrt));
   initial begin
      forever #20 clk_i = ~clk_i;
   end
   function automatic logic [7:0] pick(input int s);
      case (s)
         0: return ctrl;
         1: return en;
         2: return sta;
         3: return {7'h00, asrt};
         default: return plen[7:0];
      endcase
   endfunction : pick
   task automatic note(input int s, input logic [7:0] e);
      repeat (3) @(posedge clk_i);
      #2;
      q.push_back('{s, e});
      -> go;
      @(posedge clk_i);
      #1;
   endtask : note
   task automatic pulse(input logic [4:0] e);
      @(posedge clk_i);
      #1;
      ev = e | (ev & 5'h02);
      @(posedge clk_i);
      #1;
      ev = ev & 5'h02;
   endtask : pulse
   task automatic test_done;
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : test_done
   always @(go) begin
      n = q.pop_front();
      compares++;
      if (pick(n.sel) !== n.exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", nm[n.sel], n.exp, pick(n.sel));
      end
   end
   initial begin
      #200000;
      err_count++;
      test_done();
   end
   initial begin
      repeat (8) @(posedge clk_i);
      #1;
      sys_rst_i = 1'b0;
      note(0, RST_CTRL);
      note(1, RST_EN);
      note(2, RST_STA);
      note(3, 8'h01);
      i_host.wr(ADDR_STA, 8'h00);
      note(2, RST_STA);
      i_host.wr(ADDR_STA, 8'h01);
      note(2, 8'h08);
      note(3, 8'h00);
      i_host.wr(ADDR_EN, 8'h78);
      note(1, 8'h00);
      for (int i = 2; i < 5; i++) begin
         pulse(5'h01 << i);
         note(2, (i == 4) ? 8'h88 : 8'h0c);
         note(3, 8'h00);
         i_host.wr(ADDR_STA, 8'h84);
      end
      pulse(5'h10);
      i_host.wr(ADDR_EN, 8'h80);
      note(1, 8'h80);
      note(3, 8'h01);
      i_host.wr(ADDR_CTRL, 8'h00);
      note(3, 8'h00);
      rnd = lfsr(rnd);
      i_host.wr(8'h10 | rnd[7:0], rnd[15:8]);
      note(0, 8'h00);
      ev.fifo_nonempty = 1'b1;
      i_host.wr(ADDR_STA, 8'h82);
      note(2, 8'h0a);
      ev.fifo_nonempty = 1'b0;
      i_host.wr(ADDR_STA, 8'h02);
      note(2, 8'h08);
      i_host.wr(ADDR_CTRL, 8'h07);
      plen = 0;
      pulse(5'h10);
      repeat (20) begin
         @(posedge clk_i);
         #2;
         plen += asrt;
      end
      note(4, 8'(PULSE_CYC));
      i_host.wr(ADDR_CTRL, 8'h05);
      note(3, 8'h01);
      note(0, 8'h05);
      test_done();
   end
   function automatic logic [16:0] lfsr(input logic [16:0] x);
      return {x[15:0], x[16] ^ x[13]};
   endfunction : lfsr
endmodule : tkirq_ctrl_tb_top
`default_nettype wire
